// ---- cpu_regs_pkg.sv ----
package cpu_regs_pkg;
  localparam int          data_width      = 32;
  localparam int          addr_width      = 8;
  localparam int          pc_width        = 20;
  localparam int          base_width      = 16;
  localparam int          psw_width       = 11;
  localparam int          ppl_width       = 3;
  // register byte addresses
  localparam logic [7:0]  addr_frame_base = 8'h00;
  localparam logic [7:0]  addr_static_base = 8'h04;
  localparam logic [7:0]  addr_vector_base = 8'h08;
  localparam logic [7:0]  addr_program_counter = 8'h0C;
  localparam logic [7:0]  addr_user_sp    = 8'h10;
  localparam logic [7:0]  addr_intr_sp    = 8'h14;
  localparam logic [7:0]  addr_psw        = 8'h18;
  localparam logic [7:0]  addr_active_sp  = 8'h1C;
  // status word field positions and trap limit
  localparam int          bit_carry       = 0;
  localparam int          bit_debug       = 1;
  localparam int          bit_zero        = 2;
  localparam int          bit_sign        = 3;
  localparam int          bit_bank        = 4;
  localparam int          bit_overflow    = 5;
  localparam int          bit_int_enable  = 6;
  localparam int          bit_stack_sel   = 7;
  localparam int          bit_ppl_lo      = 8;
  localparam int          bit_ppl_hi      = 10;
  localparam int          bit_reserved    = 11;
  localparam int          trap_limit      = 31;
  // reset values and bus response codes
  localparam logic [15:0] reset_base      = 16'h0000;
  localparam logic [19:0] reset_pc        = 20'h0_0000;
  localparam logic [11:0] reset_psw       = 12'h000;
  localparam logic [1:0]  resp_okay       = 2'h0;
  localparam logic [1:0]  resp_slverr     = 2'h2;
endpackage : cpu_regs_pkg

// ---- cpu_control_register_set.sv ----
// Operation
// - frame base is a 16-bit register for frame-relative addressing
// - vector table base is a 20-bit register holding vector table start
// - program counter is 20 bits and holds next instruction address
// - two 16-bit stack pointers, user and interrupt, chosen by stack select
// - static base is a 16-bit register for static-relative addressing
// - status word is 11 bits reflecting current cpu state
// - carry takes carry, borrow or shifted-out bit of the affecting operation
// - zero bit is 1 for a zero result, 0 otherwise
// - sign bit is 1 for a negative result, 0 otherwise
// - bank select 0 picks register bank 0, 1 picks bank 1
// - overflow bit is 1 when the operation overflowed, 0 otherwise
// - maskable interrupts blocked while enable is 0, allowed while 1
// - accepting an interrupt clears interrupt enable
// - stack select 0 picks interrupt pointer, 1 picks user pointer
// - hardware interrupt or trap 0 to 31 clears stack select
// - priority level field is three bits, levels 0 to 7
// - interrupt allowed only if its priority exceeds current level
// - software writes 0 to the reserved bit; reads may return anything
//
// Added by the designer: the AXI4-Lite slave port and the register addresses.
module cpu_control_register_set (
  // clock and reset
  input  wire  logic                          aclk,
  input  wire  logic                          aresetn,
  // axi4-lite write address
  input  wire  logic                          s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire  logic [cpu_regs_pkg::addr_width-1:0] s_axi_awaddr,
  input  wire  logic [2:0]                    s_axi_awprot,
  // axi4-lite write data
  input  wire  logic                          s_axi_wvalid,
  output logic                                s_axi_wready,
  input  wire  logic [31:0]                   s_axi_wdata,
  input  wire  logic [3:0]                    s_axi_wstrb,
  // axi4-lite write response
  output logic                                s_axi_bvalid,
  input  wire  logic                          s_axi_bready,
  output logic [1:0]                          s_axi_bresp,
  // axi4-lite read address
  input  wire  logic                          s_axi_arvalid,
  output logic                                s_axi_arready,
  input  wire  logic [cpu_regs_pkg::addr_width-1:0] s_axi_araddr,
  input  wire  logic [2:0]                    s_axi_arprot,
  // axi4-lite read data
  output logic                                s_axi_rvalid,
  input  wire  logic                          s_axi_rready,
  output logic [31:0]                         s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  // execution unit side
  input  wire  logic                          pc_advance,
  input  wire  logic [cpu_regs_pkg::pc_width-1:0] next_pc,
  input  wire  logic                          flags_update,
  input  wire  logic [3:0]                    flags_affect,
  input  wire  logic [15:0]                   alu_result,
  input  wire  logic                          alu_carry,
  input  wire  logic                          alu_overflow,
  // interrupt side
  input  wire  logic                          irq_request,
  input  wire  logic [cpu_regs_pkg::ppl_width-1:0] irq_priority,
  input  wire  logic                          irq_accept,
  input  wire  logic                          irq_hardware,
  input  wire  logic                          trap_execute,
  input  wire  logic [5:0]                    trap_number,
  // register views
  output logic [cpu_regs_pkg::base_width-1:0] frame_base_out,
  output logic [cpu_regs_pkg::base_width-1:0] static_base_out,
  output logic [cpu_regs_pkg::pc_width-1:0]   vector_base_out,
  output logic [cpu_regs_pkg::pc_width-1:0]   program_counter_out,
  output logic [cpu_regs_pkg::base_width-1:0] active_stack_pointer,
  output logic                                bank_select,
  output logic                                irq_allowed
);
  import cpu_regs_pkg::*;

  logic [15:0] frame_base;
  logic [15:0] static_base;
  logic [19:0] vector_table_base;
  logic [19:0] program_counter;
  logic [15:0] user_stack_pointer;
  logic [15:0] interrupt_stack_pointer;
  logic [11:0] processor_status_word;
  logic [2:0]  processor_priority_level;
  logic        flag_carry;
  logic        flag_debug;
  logic        flag_zero;
  logic        flag_sign;
  logic        flag_bank;
  logic        flag_overflow;
  logic        flag_int_enable;
  logic        flag_stack_sel;

  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;
  logic        write_hit;
  logic        read_hit;
  logic [31:0] read_value;
  logic [31:0] merged;
  logic        wr_frame_base;
  logic        wr_static_base;
  logic        wr_vector_base;
  logic        wr_program_counter;
  logic        wr_user_sp;
  logic        wr_intr_sp;
  logic        wr_psw;
  logic        stack_clear;

  // write channel capture, in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;

  // one write strobe per register
  assign wr_frame_base      = do_write && (aw_addr == addr_frame_base);
  assign wr_static_base     = do_write && (aw_addr == addr_static_base);
  assign wr_vector_base     = do_write && (aw_addr == addr_vector_base);
  assign wr_program_counter = do_write && (aw_addr == addr_program_counter);
  assign wr_user_sp         = do_write && (aw_addr == addr_user_sp);
  assign wr_intr_sp         = do_write && (aw_addr == addr_intr_sp);
  assign wr_psw             = do_write && (aw_addr == addr_psw);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_comb begin
    write_hit = 1'b1;
    case (aw_addr)
      addr_frame_base, addr_static_base, addr_vector_base, addr_program_counter,
      addr_user_sp, addr_intr_sp, addr_psw: write_hit = 1'b1;
      default: write_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= resp_okay;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= write_hit ? resp_okay : resp_slverr;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // byte-lane merge of write data over the addressed register
  always_comb begin
    merged = 32'h0000_0000;
    case (aw_addr)
      addr_frame_base:      merged = {16'h0000, frame_base};
      addr_static_base:     merged = {16'h0000, static_base};
      addr_vector_base:     merged = {12'h000, vector_table_base};
      addr_program_counter: merged = {12'h000, program_counter};
      addr_user_sp:         merged = {16'h0000, user_stack_pointer};
      addr_intr_sp:         merged = {16'h0000, interrupt_stack_pointer};
      addr_psw:             merged = {20'h0_0000, processor_status_word};
      default:              merged = 32'h0000_0000;
    endcase
    for (int i = 0; i < 4; i++) begin
      if (w_strb[i]) begin
        merged[i*8 +: 8] = w_data[i*8 +: 8];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_base <= reset_base;
    end else if (wr_frame_base) begin
      frame_base <= merged[15:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      static_base <= reset_base;
    end else if (wr_static_base) begin
      static_base <= merged[15:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vector_table_base <= reset_pc;
    end else if (wr_vector_base) begin
      vector_table_base <= merged[19:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      program_counter <= reset_pc;
    end else if (pc_advance) begin
      program_counter <= next_pc;
    end else if (wr_program_counter) begin
      program_counter <= merged[19:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      user_stack_pointer <= reset_base;
    end else if (wr_user_sp) begin
      user_stack_pointer <= merged[15:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interrupt_stack_pointer <= reset_base;
    end else if (wr_intr_sp) begin
      interrupt_stack_pointer <= merged[15:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_carry <= reset_psw[bit_carry];
    end else if (flags_update && flags_affect[0]) begin
      flag_carry <= alu_carry;
    end else if (wr_psw) begin
      flag_carry <= merged[bit_carry];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_zero <= reset_psw[bit_zero];
    end else if (flags_update && flags_affect[1]) begin
      flag_zero <= (alu_result == 16'h0000);
    end else if (wr_psw) begin
      flag_zero <= merged[bit_zero];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_sign <= reset_psw[bit_sign];
    end else if (flags_update && flags_affect[2]) begin
      flag_sign <= alu_result[15];
    end else if (wr_psw) begin
      flag_sign <= merged[bit_sign];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_overflow <= reset_psw[bit_overflow];
    end else if (flags_update && flags_affect[3]) begin
      flag_overflow <= alu_overflow;
    end else if (wr_psw) begin
      flag_overflow <= merged[bit_overflow];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_int_enable <= reset_psw[bit_int_enable];
    end else if (irq_accept) begin
      flag_int_enable <= 1'b0;
    end else if (wr_psw) begin
      flag_int_enable <= merged[bit_int_enable];
    end
  end

  assign stack_clear = (irq_accept && irq_hardware) || (trap_execute && (trap_number <= 6'(trap_limit)));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_stack_sel <= reset_psw[bit_stack_sel];
    end else if (stack_clear) begin
      flag_stack_sel <= 1'b0;
    end else if (wr_psw) begin
      flag_stack_sel <= merged[bit_stack_sel];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_debug               <= reset_psw[bit_debug];
      flag_bank                <= reset_psw[bit_bank];
      processor_priority_level <= reset_psw[bit_ppl_hi:bit_ppl_lo];
    end else if (wr_psw) begin
      flag_debug               <= merged[bit_debug];
      flag_bank                <= merged[bit_bank];
      processor_priority_level <= merged[bit_ppl_hi:bit_ppl_lo];
    end
  end

  // status word view, reserved bit reads 0
  always_comb begin
    processor_status_word                        = 12'h000;
    processor_status_word[bit_carry]             = flag_carry;
    processor_status_word[bit_debug]             = flag_debug;
    processor_status_word[bit_zero]              = flag_zero;
    processor_status_word[bit_sign]              = flag_sign;
    processor_status_word[bit_bank]              = flag_bank;
    processor_status_word[bit_overflow]          = flag_overflow;
    processor_status_word[bit_int_enable]        = flag_int_enable;
    processor_status_word[bit_stack_sel]         = flag_stack_sel;
    processor_status_word[bit_ppl_hi:bit_ppl_lo] = processor_priority_level;
  end

  assign irq_allowed = irq_request && processor_status_word[bit_int_enable]
                       && (irq_priority > processor_priority_level);

  assign active_stack_pointer = processor_status_word[bit_stack_sel] ? user_stack_pointer
                                                                     : interrupt_stack_pointer;
  assign bank_select         = processor_status_word[bit_bank];
  assign frame_base_out      = frame_base;
  assign static_base_out     = static_base;
  assign vector_base_out     = vector_table_base;
  assign program_counter_out = program_counter;

  // read channel
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    read_hit   = 1'b1;
    read_value = 32'h0000_0000;
    case (s_axi_araddr)
      addr_frame_base:      read_value = {16'h0000, frame_base};
      addr_static_base:     read_value = {16'h0000, static_base};
      addr_vector_base:     read_value = {12'h000, vector_table_base};
      addr_program_counter: read_value = {12'h000, program_counter};
      addr_user_sp:         read_value = {16'h0000, user_stack_pointer};
      addr_intr_sp:         read_value = {16'h0000, interrupt_stack_pointer};
      addr_psw:             read_value = {20'h0_0000, processor_status_word};
      addr_active_sp:       read_value = {16'h0000, active_stack_pointer};
      default:              read_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= resp_okay;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= read_value;
      s_axi_rresp  <= read_hit ? resp_okay : resp_slverr;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : cpu_control_register_set

// ---- cpu_regs_monitor.sv ----
module cpu_regs_monitor (
  // clock, reset and bus
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [cpu_regs_pkg::addr_width-1:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  // core side
  input wire logic pc_advance,
  input wire logic [cpu_regs_pkg::pc_width-1:0] next_pc,
  input wire logic irq_request,
  input wire logic [cpu_regs_pkg::ppl_width-1:0] irq_priority,
  input wire logic irq_accept,
  input wire logic [cpu_regs_pkg::pc_width-1:0] program_counter_out,
  input wire logic bank_select,
  input wire logic irq_allowed
);
  timeunit 1ns;
  timeprecision 1ps;
  import cpu_regs_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h1C
    |=> s_axi_rresp == resp_slverr && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_pc_load: assert property (pc_advance |=> program_counter_out == $past(next_pc))
    else $error("pc not loaded");
  a_pc_hold: assert property (!pc_advance ##1 !$rose(s_axi_bvalid) |-> $stable(program_counter_out))
    else $error("pc moved without cause");
  a_bank_hold: assert property (!$rose(s_axi_bvalid) |-> $stable(bank_select))
    else $error("bank select moved without write");
  a_irq_gate: assert property (irq_allowed |-> irq_request && irq_priority != 3'h0)
    else $error("interrupt allowed without cause");
  a_accept_mask: assert property (irq_accept |=> !irq_allowed)
    else $error("accept left interrupts enabled");
endmodule : cpu_regs_monitor

bind cpu_control_register_set cpu_regs_monitor i_monitor (.*);

// ---- testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import cpu_regs_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, bank_select, irq_allowed;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0, irq_priority = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF, flags_affect = 4'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic pc_advance = 1'b0, flags_update = 1'b0, alu_carry = 1'b0, alu_overflow = 1'b0;
  logic irq_request = 1'b0, irq_accept = 1'b0, irq_hardware = 1'b0, trap_execute = 1'b0;
  logic [19:0] next_pc = 20'h0_0000, program_counter_out, vector_base_out;
  logic [15:0] alu_result = 16'h0000, frame_base_out, static_base_out, active_stack_pointer;
  logic [5:0] trap_number = 6'h00;
  int n_fail = 0;
  int check_count = 0;

  always #5 aclk = ~aclk;
  cpu_control_register_set i_cpu_control_register_set (.*);

  task automatic summarize;
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic bound(input int n);
    if (n == 50) begin
      n_fail++;
      $display("ERROR handshake expected answer seen none");
      summarize();
    end
  endtask : bound

  // ready raised late so the answer must stand
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aw_hit, w_hit, b_hit;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      aw_hit = s_axi_awvalid && s_axi_awready;
      w_hit = s_axi_wvalid && s_axi_wready;
      b_hit = s_axi_bvalid && s_axi_bready;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (aw_hit) s_axi_awvalid <= 1'b0;
      if (w_hit) s_axi_wvalid <= 1'b0;
      if (b_hit) break;
      s_axi_bready <= (n >= 2);
    end
    s_axi_bready <= 1'b0;
    bound(n);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a);
    int n;
    logic ar_hit, r_hit;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      ar_hit = s_axi_arvalid && s_axi_arready;
      r_hit = s_axi_rvalid && s_axi_rready;
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ar_hit) s_axi_arvalid <= 1'b0;
      if (r_hit) break;
      s_axi_rready <= (n >= 1);
    end
    s_axi_rready <= 1'b0;
    bound(n);
  endtask : axi_read

  task automatic test_regs;
    logic [7:0] a;
    axi_read(addr_frame_base);
    check("frame_base reset", 32'h0000_0000, rd);
    for (int i = 0; i < 6; i++) begin
      a = 8'(4 * i);
      axi_write(a, 32'h9876_5432 + 32'(a));
      axi_read(a);
      check("readback", (32'h9876_5432 + 32'(a)) & ((i == 2 || i == 3) ? 32'h000F_FFFF : 32'h0000_FFFF), rd);
    end
    check("frame_base_out", 32'h0000_5432, 32'(frame_base_out));
    check("static_base_out", 32'h0000_5436, 32'(static_base_out));
    check("vector_base_out", 32'h0006_543A, 32'(vector_base_out));
    axi_write(8'h40, 32'hFFFF_FFFF);
    check("unmapped bresp", 32'(resp_slverr), 32'(resp));
    axi_read(8'h40);
    check("unmapped rdata", 32'h0000_0000, rd);
    check("unmapped rresp", 32'(resp_slverr), 32'(resp));
    check("frame_base kept", 32'h0000_5432, 32'(frame_base_out));
    $display("test_regs done");
  endtask : test_regs

  task automatic test_status;
    axi_write(addr_psw, 32'h0000_0090);
    check("psw bresp", 32'(resp_okay), 32'(resp));
    check("bank_select", 32'h0000_0001, 32'(bank_select));
    check("user sp active", 32'h0000_5442, 32'(active_stack_pointer));
    axi_read(addr_psw);
    check("status word", 32'h0000_0090, rd);
    axi_write(addr_psw, 32'h0000_0000);
    check("intr sp active", 32'h0000_5446, 32'(active_stack_pointer));
    axi_read(addr_active_sp);
    check("active sp read", 32'h0000_5446, rd);
    $display("test_status done");
  endtask : test_status

  task automatic alu_step(input logic [3:0] f, input logic [15:0] r, input logic c, input logic o,
                          input logic [31:0] exp);
    @(posedge aclk);
    flags_update <= 1'b1;
    flags_affect <= f;
    alu_result <= r;
    alu_carry <= c;
    alu_overflow <= o;
    @(posedge aclk);
    flags_update <= 1'b0;
    axi_read(addr_psw);
    check("flag bits", exp, rd & 32'h0000_002D);
  endtask : alu_step

  task automatic test_flags;
    alu_step(4'hF, 16'h0000, 1'b1, 1'b0, 32'h0000_0005);
    alu_step(4'h4, 16'h8000, 1'b0, 1'b0, 32'h0000_000D);
    alu_step(4'hF, 16'h0001, 1'b0, 1'b1, 32'h0000_0020);
    alu_step(4'h0, 16'h8000, 1'b1, 1'b0, 32'h0000_0020);
    alu_step(4'h1, 16'h0000, 1'b1, 1'b0, 32'h0000_0021);
    $display("test_flags done");
  endtask : test_flags

  task automatic event_step(input logic hw, input logic trap, input logic [5:0] num, input logic [31:0] sp);
    axi_write(addr_psw, 32'h0000_03C0);
    irq_accept <= !trap;
    irq_hardware <= hw;
    trap_execute <= trap;
    trap_number <= num;
    @(posedge aclk);
    irq_accept <= 1'b0;
    trap_execute <= 1'b0;
    @(negedge aclk);
    check("active sp after event", sp, 32'(active_stack_pointer));
  endtask : event_step

  task automatic test_irq;
    axi_write(addr_psw, 32'h0000_03C0);
    irq_request <= 1'b1;
    for (int p = 0; p < 8; p++) begin
      irq_priority <= 3'(p);
      @(negedge aclk);
      check("irq_allowed by level", 32'(p > 3), 32'(irq_allowed));
      @(posedge aclk);
    end
    axi_write(addr_psw, 32'h0000_0380);
    check("irq masked", 32'h0000_0000, 32'(irq_allowed));
    event_step(1'b0, 1'b0, 6'h00, 32'h0000_5442);
    check("irq after accept", 32'h0000_0000, 32'(irq_allowed));
    event_step(1'b1, 1'b0, 6'h00, 32'h0000_5446);
    event_step(1'b0, 1'b1, 6'h20, 32'h0000_5442);
    event_step(1'b0, 1'b1, 6'h1F, 32'h0000_5446);
    irq_request <= 1'b0;
    $display("test_irq done");
  endtask : test_irq

  task automatic test_pc;
    @(posedge aclk);
    pc_advance <= 1'b1;
    next_pc <= 20'hA_BCDE;
    @(posedge aclk);
    pc_advance <= 1'b0;
    axi_read(addr_program_counter);
    check("program counter", 32'h000A_BCDE, rd);
    check("program_counter_out", 32'h000A_BCDE, 32'(program_counter_out));
    $display("test_pc done");
  endtask : test_pc

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    test_regs();
    test_status();
    test_flags();
    test_irq();
    test_pc();
    summarize();
  end
endmodule : testbench
